// *** src/ibr_pkg.sv ***
// package: register map, status codes, timing and types of the i2c byte controller
package ibr_pkg;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_OWN = 4'hC;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OWN_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] ST_START = 8'h08;
    localparam logic [7:0] ST_RSTART = 8'h10;
    localparam logic [7:0] ST_MT_AACK = 8'h18;
    localparam logic [7:0] ST_MT_ANACK = 8'h20;
    localparam logic [7:0] ST_MT_DACK = 8'h28;
    localparam logic [7:0] ST_MT_DNACK = 8'h30;
    localparam logic [7:0] ST_ARB = 8'h38;
    localparam logic [7:0] ST_AACK = 8'h40;
    localparam logic [7:0] ST_ANACK = 8'h48;
    localparam logic [7:0] ST_DACK = 8'h50;
    localparam logic [7:0] ST_DNACK = 8'h58;
    localparam logic [7:0] ST_SR_OWN = 8'h60;
    localparam logic [7:0] ST_SR_ARB = 8'h68;
    localparam logic [7:0] ST_SR_DACK = 8'h80;
    localparam logic [7:0] ST_SR_DNACK = 8'h88;
    localparam logic [7:0] ST_SR_GC = 8'hD0;
    localparam logic [7:0] ST_SR_GCARB = 8'hD8;
    localparam logic [7:0] ST_IDLE = 8'hF8;
    localparam int CLK_NS = 40;
    localparam int SCL_HALF_NS = 160;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] SCL_HALF_LAST = 4'(SCL_HALF_CYC - 1);
    typedef struct packed {
        logic scl;
        logic sda;
    } ibr_pins_t;
    typedef struct packed {
        logic ack_en;
        logic ena;
        logic begin_req;
        logic halt;
        logic si;
        logic [1:0] unused;
        logic mode;
    } ibr_ctrl_t;
    typedef struct packed {
        logic en;
        logic [7:0] code;
    } ibr_post_t;
    typedef enum logic [3:0] {
        M_IDLE = 4'h0,
        M_START = 4'h1,
        M_WAIT = 4'h3,
        M_LOW = 4'h2,
        M_HIGH = 4'h6,
        M_RS1 = 4'h7,
        M_RS2 = 4'h5,
        M_STOP1 = 4'h4,
        M_STOP2 = 4'hC,
        M_STOP3 = 4'hD
    } ibr_mst_t;
endpackage

// *** src/ibr_sync.sv ***
// two-stage synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none
module ibr_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '1;
            q_r <= '1;
        end else if (ce) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end
    assign q = q_r;
endmodule // ibr_sync
`default_nettype wire

// *** src/ibr_top.sv ***
// i2c byte-mode controller: avalon registers, master engine and bus watcher
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ibr_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire ibr_pkg::ibr_pins_t pin_in,
    output var ibr_pkg::ibr_pins_t pin_out,
    output var ibr_pkg::ibr_pins_t pin_oe_n
);
    import ibr_pkg::*;

    function automatic logic half_done(input logic [3:0] c);
        return c == SCL_HALF_LAST;
    endfunction

    ibr_pins_t pin_s;
    ibr_sync #(.W(2)) u_sync (
        .clk(core_clk),
        .rst(sys_rst),
        .ce(ce),
        .d(pin_in),
        .q(pin_s)
    );

    // register group
    ibr_ctrl_t ctrl_r, ctrl_nxt;
    logic [7:0] own_r, own_nxt, data_r, data_nxt, status_r, status_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt, wr_commit;
    // master group
    ibr_mst_t m_st_r, m_nxt;
    logic [3:0] cnt_r, cnt_nxt, bit_r, bit_nxt;
    logic first_r, first_nxt, tx_r, tx_nxt, wr_r, wr_nxt, rep_r, rep_nxt;
    logic m_sda_r, msda_nxt, m_scl_r, mscl_nxt;
    ibr_post_t post_m, post_w;
    logic ld_m, ld_w, clr_halt, lost_set;
    // watcher group
    logic scl_q_r, sda_q_r, busy_r, busy_nxt;
    logic [3:0] w_cnt_r, wcnt_nxt;
    logic [7:0] w_sh_r, wsh_nxt, s_code_r, scode_nxt;
    logic w_first_r, wfirst_nxt, s_addr_r, saddr_nxt, s_ack_r, sack_nxt;
    logic s_pend_r, spend_nxt, w_lost_r, wlost_nxt;
    logic rise, fall, start_ev, stop_ev, hit_own, hit_gc;

    // one wait state: the read mux is registered so data stand at the release edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_commit = avs_write & ack_r & avs_byteenable[0];
    assign avs_readdata = rdata_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        own_nxt = own_r;
        data_nxt = data_r;
        status_nxt = status_r;
        rdata_nxt = rdata_r;
        ack_nxt = (avs_read | avs_write) & ~ack_r;
        if (clr_halt) begin
            ctrl_nxt.halt = 1'b0;
        end
        if (wr_commit) begin
            case (avs_address)
                OFS_CTRL: begin
                    ctrl_nxt = ibr_ctrl_t'(avs_writedata[7:0]);
                    ctrl_nxt.unused = 2'b00;
                    ctrl_nxt.si = 1'b0;
                end
                OFS_DATA: data_nxt = avs_writedata[7:0];
                OFS_OWN: own_nxt = avs_writedata[7:0];
                default: ;
            endcase
        end
        if (ld_m | ld_w) begin
            data_nxt = w_sh_r;
        end
        // a posted event wins over a clearing write in the same cycle
        if (post_m.en | post_w.en) begin
            ctrl_nxt.si = 1'b1;
            status_nxt = post_m.en ? post_m.code : post_w.code;
        end
        if (avs_read & ~ack_r) begin
            case (avs_address)
                OFS_CTRL: rdata_nxt = {24'h00_0000, ctrl_r};
                OFS_STAT: rdata_nxt = {24'h00_0000, status_r};
                OFS_DATA: rdata_nxt = {24'h00_0000, data_r};
                OFS_OWN: rdata_nxt = {24'h00_0000, own_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_r <= ibr_ctrl_t'(CTRL_RST);
            own_r <= OWN_RST;
            data_r <= DATA_RST;
            status_r <= ST_IDLE;
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            own_r <= own_nxt;
            data_r <= data_nxt;
            status_r <= status_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    // master engine: scl is generated here, stretching honoured in high phases
    always_comb begin
        m_nxt = m_st_r;
        cnt_nxt = cnt_r + 4'h1;
        bit_nxt = bit_r;
        first_nxt = first_r;
        tx_nxt = tx_r;
        wr_nxt = wr_r;
        rep_nxt = rep_r;
        msda_nxt = m_sda_r;
        mscl_nxt = m_scl_r;
        post_m = '0;
        ld_m = 1'b0;
        clr_halt = 1'b0;
        lost_set = 1'b0;
        case (m_st_r)
            M_IDLE: begin
                cnt_nxt = 4'h0;
                msda_nxt = 1'b0;
                mscl_nxt = 1'b0;
                rep_nxt = 1'b0;
                if (ctrl_r.begin_req && !busy_r && !ctrl_r.si) begin
                    m_nxt = M_START;
                end
            end
            M_START: begin
                msda_nxt = 1'b1;
                if (half_done(cnt_r)) begin
                    m_nxt = M_WAIT;
                    mscl_nxt = 1'b1;
                    first_nxt = 1'b1;
                    post_m = '{en: 1'b1, code: rep_r ? ST_RSTART : ST_START};
                end
            end
            M_WAIT: begin
                cnt_nxt = 4'h0;
                mscl_nxt = 1'b1;
                if (!ctrl_r.si) begin
                    bit_nxt = 4'h0;
                    m_nxt = M_LOW;
                    if (first_r) begin
                        tx_nxt = 1'b1;
                    end else if (status_r == ST_AACK || status_r == ST_DACK) begin
                        tx_nxt = 1'b0;
                    end else if (ctrl_r.halt) begin
                        m_nxt = M_STOP1;
                    end else if (ctrl_r.begin_req) begin
                        m_nxt = M_RS1;
                    end else begin
                        tx_nxt = wr_r;
                    end
                end
            end
            M_LOW: begin
                mscl_nxt = 1'b1;
                if (bit_r[3]) begin
                    msda_nxt = !tx_r && ctrl_r.ack_en;
                end else begin
                    msda_nxt = tx_r && !data_r[~bit_r[2:0]];
                end
                if (half_done(cnt_r)) begin
                    m_nxt = M_HIGH;
                    cnt_nxt = 4'h0;
                    mscl_nxt = 1'b0;
                end
            end
            M_HIGH: begin
                if (!pin_s.scl) begin
                    cnt_nxt = 4'h0;
                end else if (half_done(cnt_r)) begin
                    cnt_nxt = 4'h0;
                    // released a bit we own yet the line reads low
                    if (!m_sda_r && !pin_s.sda && (bit_r[3] != tx_r)) begin
                        m_nxt = M_IDLE;
                        msda_nxt = 1'b0;
                        if (first_r && !bit_r[3]) begin
                            lost_set = 1'b1;
                        end else begin
                            post_m = '{en: 1'b1, code: ST_ARB};
                        end
                    end else if (!bit_r[3]) begin
                        bit_nxt = bit_r + 4'h1;
                        m_nxt = M_LOW;
                        mscl_nxt = 1'b1;
                    end else begin
                        m_nxt = M_WAIT;
                        mscl_nxt = 1'b1;
                        first_nxt = 1'b0;
                        post_m.en = 1'b1;
                        if (first_r) begin
                            wr_nxt = !data_r[0];
                            if (data_r[0]) begin
                                post_m.code = pin_s.sda ? ST_ANACK : ST_AACK;
                            end else begin
                                post_m.code = pin_s.sda ? ST_MT_ANACK : ST_MT_AACK;
                            end
                        end else if (tx_r) begin
                            post_m.code = pin_s.sda ? ST_MT_DNACK : ST_MT_DACK;
                        end else begin
                            ld_m = 1'b1;
                            post_m.code = m_sda_r ? ST_DACK : ST_DNACK;
                        end
                    end
                end
            end
            M_RS1: begin
                mscl_nxt = 1'b1;
                msda_nxt = 1'b0;
                if (half_done(cnt_r)) begin
                    m_nxt = M_RS2;
                    cnt_nxt = 4'h0;
                    mscl_nxt = 1'b0;
                end
            end
            M_RS2: begin
                if (!pin_s.scl) begin
                    cnt_nxt = 4'h0;
                end else if (half_done(cnt_r)) begin
                    m_nxt = M_START;
                    cnt_nxt = 4'h0;
                    rep_nxt = 1'b1;
                end
            end
            M_STOP1: begin
                mscl_nxt = 1'b1;
                msda_nxt = 1'b1;
                if (half_done(cnt_r)) begin
                    m_nxt = M_STOP2;
                    cnt_nxt = 4'h0;
                    mscl_nxt = 1'b0;
                end
            end
            M_STOP2: begin
                if (!pin_s.scl) begin
                    cnt_nxt = 4'h0;
                end else if (half_done(cnt_r)) begin
                    m_nxt = M_STOP3;
                    cnt_nxt = 4'h0;
                    msda_nxt = 1'b0;
                    clr_halt = 1'b1;
                end
            end
            M_STOP3: begin
                if (half_done(cnt_r)) begin
                    m_nxt = M_IDLE;
                end
            end
            default: m_nxt = M_IDLE;
        endcase
        if (!ctrl_r.ena) begin
            m_nxt = M_IDLE;
            msda_nxt = 1'b0;
            mscl_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            m_st_r <= M_IDLE;
            cnt_r <= 4'h0;
            bit_r <= 4'h0;
            first_r <= 1'b0;
            tx_r <= 1'b0;
            wr_r <= 1'b0;
            rep_r <= 1'b0;
            m_sda_r <= 1'b0;
            m_scl_r <= 1'b0;
        end else if (ce) begin
            m_st_r <= m_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            first_r <= first_nxt;
            tx_r <= tx_nxt;
            wr_r <= wr_nxt;
            rep_r <= rep_nxt;
            m_sda_r <= msda_nxt;
            m_scl_r <= mscl_nxt;
        end
    end

    // bus watcher: always shifts, even with ack enable low, so re-enabling acts at once
    assign rise = pin_s.scl & ~scl_q_r;
    assign fall = ~pin_s.scl & scl_q_r;
    assign start_ev = pin_s.scl & scl_q_r & sda_q_r & ~pin_s.sda;
    assign stop_ev = pin_s.scl & scl_q_r & ~sda_q_r & pin_s.sda;
    assign hit_own = ctrl_r.ack_en && w_sh_r[7:1] == own_r[7:1] && !w_sh_r[0];
    assign hit_gc = ctrl_r.ack_en && own_r[0] && w_sh_r == GC_ADDR;

    always_comb begin
        busy_nxt = busy_r;
        wcnt_nxt = w_cnt_r;
        wsh_nxt = w_sh_r;
        scode_nxt = s_code_r;
        wfirst_nxt = w_first_r;
        saddr_nxt = s_addr_r;
        sack_nxt = s_ack_r;
        spend_nxt = s_pend_r;
        wlost_nxt = w_lost_r;
        post_w = '0;
        ld_w = 1'b0;
        if (start_ev || stop_ev) begin
            busy_nxt = start_ev;
            // the scl fall that closes a start carries no bit, so it must not be counted
            wcnt_nxt = 4'hf;
            wfirst_nxt = 1'b1;
            saddr_nxt = 1'b0;
            sack_nxt = 1'b0;
            spend_nxt = 1'b0;
            wlost_nxt = w_lost_r & start_ev;
        end else if (fall && w_cnt_r == 4'hf) begin
            wcnt_nxt = 4'h0;
        end else if (rise && !w_cnt_r[3]) begin
            wsh_nxt = {w_sh_r[6:0], pin_s.sda};
        end else if (fall && w_cnt_r[3]) begin
            wcnt_nxt = 4'h0;
            wfirst_nxt = 1'b0;
            sack_nxt = 1'b0;
            spend_nxt = 1'b0;
            if (s_pend_r) begin
                post_w = '{en: 1'b1, code: s_code_r};
                ld_w = !w_first_r;
                saddr_nxt = s_ack_r;
            end
        end else if (fall) begin
            wcnt_nxt = w_cnt_r + 4'h1;
            if (w_cnt_r == 4'h7 && ctrl_r.ena && m_st_r == M_IDLE) begin
                if (w_first_r && (hit_own || hit_gc)) begin
                    sack_nxt = 1'b1;
                    spend_nxt = 1'b1;
                    wlost_nxt = 1'b0;
                    if (w_lost_r) begin
                        scode_nxt = hit_gc ? ST_SR_GCARB : ST_SR_ARB;
                    end else begin
                        scode_nxt = hit_gc ? ST_SR_GC : ST_SR_OWN;
                    end
                end else if (w_first_r && w_lost_r) begin
                    post_w = '{en: 1'b1, code: ST_ARB};
                    wlost_nxt = 1'b0;
                end else if (!w_first_r && s_addr_r) begin
                    sack_nxt = ctrl_r.ack_en;
                    spend_nxt = 1'b1;
                    scode_nxt = ctrl_r.ack_en ? ST_SR_DACK : ST_SR_DNACK;
                end
            end
        end
        if (lost_set) begin
            wlost_nxt = 1'b1;
        end
        if (!ctrl_r.ena) begin
            saddr_nxt = 1'b0;
            sack_nxt = 1'b0;
            spend_nxt = 1'b0;
            wlost_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            busy_r <= 1'b0;
            w_cnt_r <= 4'h0;
            w_sh_r <= 8'h00;
            s_code_r <= ST_IDLE;
            w_first_r <= 1'b0;
            s_addr_r <= 1'b0;
            s_ack_r <= 1'b0;
            s_pend_r <= 1'b0;
            w_lost_r <= 1'b0;
        end else if (ce) begin
            scl_q_r <= pin_s.scl;
            sda_q_r <= pin_s.sda;
            busy_r <= busy_nxt;
            w_cnt_r <= wcnt_nxt;
            w_sh_r <= wsh_nxt;
            s_code_r <= scode_nxt;
            w_first_r <= wfirst_nxt;
            s_addr_r <= saddr_nxt;
            s_ack_r <= sack_nxt;
            s_pend_r <= spend_nxt;
            w_lost_r <= wlost_nxt;
        end
    end

    // open drain: only ever pull low
    assign pin_out = '0;
    assign pin_oe_n.scl = ~(m_scl_r | (ctrl_r.si & s_addr_r));
    assign pin_oe_n.sda = ~(m_sda_r | s_ack_r);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_stop_end;
        m_st_r == M_STOP2 ##1 m_st_r == M_STOP3;
    endsequence
    property p_start_code;
        (m_st_r == M_START && half_done(cnt_r) && !rep_r && ce && ctrl_r.ena)
            |=> (ctrl_r.si && status_r == ST_START && m_st_r == M_WAIT);
    endproperty
    a_start_code: assert property (p_start_code) else $error("start not posted");
    property p_rstart_code;
        (m_st_r == M_START && half_done(cnt_r) && rep_r && ce && ctrl_r.ena)
            |=> (ctrl_r.si && status_r == ST_RSTART);
    endproperty
    a_rstart_code: assert property (p_rstart_code) else $error("restart not posted");
    property p_arb_release;
        ($rose(ctrl_r.si) && status_r == ST_ARB) |-> (m_st_r == M_IDLE && !m_scl_r && !m_sda_r);
    endproperty
    a_arb_release: assert property (p_arb_release) else $error("bus kept after loss");
    property p_rx_after_ack;
        (m_st_r == M_WAIT && !ctrl_r.si && !first_r && status_r == ST_AACK && ctrl_r.ena && ce)
            |=> (m_st_r == M_LOW && !tx_r);
    endproperty
    a_rx_after_ack: assert property (p_rx_after_ack) else $error("no receive after 40h");
    property p_nack_stop;
        (m_st_r == M_WAIT && !ctrl_r.si && !first_r && status_r == ST_ANACK
            && ctrl_r.halt && ctrl_r.ena && ce) |=> m_st_r == M_STOP1;
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("halt not honoured");
    property p_halt_clear;
        s_stop_end |-> !ctrl_r.halt;
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("halt not cleared");
    property p_ack_drive;
        (m_st_r == M_LOW && bit_r[3] && !tx_r && cnt_r != 4'h0 && $past(ce))
            |-> m_sda_r == $past(ctrl_r.ack_en);
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("wrong ack level");
    property p_si_stretch;
        (ctrl_r.si && m_st_r == M_WAIT) |-> !pin_oe_n.scl;
    endproperty
    a_si_stretch: assert property (p_si_stretch) else $error("scl not held");
    property p_ctrl_clear;
        (wr_commit && avs_address == OFS_CTRL && !post_m.en && !post_w.en && ce) |=> !ctrl_r.si;
    endproperty
    a_ctrl_clear: assert property (p_ctrl_clear) else $error("flag not cleared");
    property p_stat_hold;
        (!post_m.en && !post_w.en) |=> $stable(status_r);
    endproperty
    a_stat_hold: assert property (p_stat_hold) else $error("status moved");
endmodule // ibr_top
`default_nettype wire

// *** tb/ibr_slave_model.sv ***
// slave transmitter model answering one read address
`timescale 1ns/1ps
`default_nettype none
module ibr_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a,
    parameter logic [7:0] D0 = 8'hc3
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe_n,
    output logic last_ack_n
);
    logic [7:0] sh;
    logic [7:0] tx;
    logic more;
    initial begin
        sda_oe_n = 1'b1;
        last_ack_n = 1'b1;
        forever begin
            @(negedge sda iff scl === 1'b1);
            for (int i = 0; i < 8; i++) begin
                @(posedge scl);
                sh = {sh[6:0], sda};
            end
            // write or foreign address: stay off the bus
            if (sh === {ADDR, 1'b1}) begin
                @(negedge scl);
                sda_oe_n = 1'b0;
                tx = D0;
                more = 1'b1;
                while (more) begin
                    for (int i = 7; i >= 0; i--) begin
                        @(negedge scl);
                        sda_oe_n = tx[i];
                    end
                    @(negedge scl);
                    sda_oe_n = 1'b1;
                    @(posedge scl);
                    last_ack_n = sda;
                    more = !sda;
                    tx = ~tx;
                end
            end
        end
    end
endmodule // ibr_slave_model
`default_nettype wire

// *** tb/tb_top.sv ***
// testbench: registers, master receiver against a slave transmitter model, address nack and restart, slave receive against a bit-banged master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ibr_pkg::*;
    localparam logic [6:0] SLV = 7'h2a;
    localparam logic [7:0] D0 = 8'hc3;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    ibr_pins_t pin_in;
    ibr_pins_t pin_oe_n;
    logic s_oe_n;
    logic s_ack_n;
    logic h_scl_oe_n = 1'b1;
    logic h_sda_oe_n = 1'b1;
    logic [7:0] q;
    int num_errors = 0;
    int checked = 0;
    // pulled-up lines, any party may pull low
    assign pin_in = {pin_oe_n.scl & h_scl_oe_n, pin_oe_n.sda & s_oe_n & h_sda_oe_n};
    ibr_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pin_in(pin_in), .pin_out(), .pin_oe_n(pin_oe_n));
    ibr_slave_model #(.ADDR(SLV), .D0(D0)) slv (.scl(pin_in.scl), .sda(pin_in.sda),
        .sda_oe_n(s_oe_n), .last_ack_n(s_ack_n));
    initial forever #20 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h00_0000, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    // polls the flag, there is no interrupt pin
    task automatic flag(input logic [7:0] st);
        q = 8'h00;
        for (int i = 0; i < 500 && q[3] !== 1'b1; i++) bus(1'b0, OFS_CTRL, 8'h00);
        chk({7'h00, pin_oe_n.scl}, 8'h00);
        rd(OFS_STAT, st);
    endtask
    task automatic step(input logic [7:0] ctrl, input logic [7:0] st);
        bus(1'b1, OFS_CTRL, ctrl);
        flag(st);
    endtask
    // bit-banged master on the far side; phases of 8 cycles, stretching waited out
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic scl_up;
        h_scl_oe_n <= 1'b1;
        hold(1);
        while (pin_in.scl !== 1'b1) hold(1);
        hold(8);
    endtask
    task automatic mbit(input logic b, output logic seen);
        h_sda_oe_n <= b;
        hold(8);
        scl_up();
        seen = pin_in.sda;
        h_scl_oe_n <= 1'b0;
        hold(1);
    endtask
    task automatic m_addr(input logic [7:0] b, input logic ack_n);
        logic seen;
        h_sda_oe_n <= 1'b0;
        hold(8);
        h_scl_oe_n <= 1'b0;
        hold(8);
        for (int i = 7; i >= 0; i--) mbit(b[i], seen);
        mbit(1'b1, seen);
        chk({7'h00, seen}, {7'h00, ack_n});
    endtask
    task automatic mstop;
        h_sda_oe_n <= 1'b0;
        hold(8);
        scl_up();
        h_sda_oe_n <= 1'b1;
        hold(8);
    endtask
    task automatic t_slave;
        bus(1'b1, OFS_OWN, 8'ha5);
        bus(1'b1, OFS_CTRL, 8'hc0);
        m_addr(8'ha4, 1'b0);
        flag(ST_SR_OWN);
        bus(1'b1, OFS_CTRL, 8'h40);
        mstop();
        m_addr(8'ha4, 1'b1);
        rd(OFS_STAT, ST_SR_OWN);
        rd(OFS_CTRL, 8'h40);
        mstop();
        bus(1'b1, OFS_CTRL, 8'hc0);
        m_addr(8'h00, 1'b0);
        flag(ST_SR_GC);
        bus(1'b1, OFS_CTRL, 8'hc0);
        mstop();
        $display("test slave done");
    endtask
    task automatic stop(input logic [7:0] ctrl);
        bus(1'b1, OFS_CTRL, ctrl);
        q = 8'hff;
        for (int i = 0; i < 200 && q[4] !== 1'b0; i++) bus(1'b0, OFS_CTRL, 8'h00);
        chk(q, ctrl & 8'hef);
    endtask
    task automatic t_regs;
        rd(OFS_STAT, ST_IDLE);
        rd(OFS_CTRL, CTRL_RST);
        bus(1'b1, OFS_OWN, 8'ha5);
        rd(OFS_OWN, 8'ha5);
        bus(1'b1, OFS_CTRL, 8'h87);
        rd(OFS_CTRL, 8'h81);
        rd(4'h2, 8'h00);
        bus(1'b1, OFS_CTRL, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_read;
        step(8'he0, ST_START);
        bus(1'b1, OFS_DATA, {SLV, 1'b1});
        step(8'hc0, ST_AACK);
        rd(OFS_STAT, ST_AACK);
        step(8'hc0, ST_DACK);
        rd(OFS_DATA, D0);
        chk({7'h00, s_ack_n}, 8'h00);
        step(8'h40, ST_DNACK);
        rd(OFS_DATA, ~D0);
        chk({7'h00, s_ack_n}, 8'h01);
        stop(8'h50);
        $display("test read done");
    endtask
    task automatic t_nack;
        step(8'he0, ST_START);
        bus(1'b1, OFS_DATA, {~SLV, 1'b1});
        step(8'hc0, ST_ANACK);
        step(8'hf0, ST_START);
        rd(OFS_CTRL, 8'he8);
        bus(1'b1, OFS_DATA, {~SLV, 1'b1});
        step(8'hc0, ST_ANACK);
        step(8'he0, ST_RSTART);
        bus(1'b1, OFS_DATA, {~SLV, 1'b0});
        step(8'hc0, ST_MT_ANACK);
        stop(8'hd0);
        $display("test nack done");
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_read();
        t_nack();
        t_slave();
        end_of_test();
    end
    initial begin
        #2_000_000;
        num_errors++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
